// File: shared/timer_flag_pkg.sv
// timer flag and lock register slice: shared constants
// assumes a 32-bit plain register port with byte offsets
package timer_flag_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FLAGS      = 8'h0c;
  localparam logic [7:0] OFF_FLAG_SET   = 8'h10;
  localparam logic [7:0] OFF_FLAG_CLEAR = 8'h14;
  localparam logic [7:0] OFF_FLAG_EN    = 8'h18;
  localparam logic [7:0] OFF_WRAP       = 8'h1c;
  localparam logic [7:0] OFF_WRAP_BUF   = 8'h20;
  localparam logic [7:0] OFF_COUNT      = 8'h24;
  localparam logic [7:0] OFF_STATUS     = 8'h28;
  localparam logic [7:0] OFF_GUARD      = 8'h2c;
  // ----------------------------------------------------------------
  // flag field layout
  // ----------------------------------------------------------------
  localparam int          FLAG_W        = 12;
  localparam int          BIT_OVERFLOW  = 0;
  localparam int          BIT_UNDERFLOW = 1;
  localparam int          BIT_DIRCHANGE = 2;
  localparam int          BIT_CHAN_LO   = 4;
  localparam int          BIT_OVR_LO    = 8;
  localparam logic [11:0] FLAG_VALID    = 12'hff7;
  // ----------------------------------------------------------------
  // reset values and key
  // ----------------------------------------------------------------
  localparam logic [31:0] WRAP_RESET     = 32'h0000ffff;
  localparam logic [31:0] WRAP_BUF_RESET = 32'h00000000;
  localparam logic [31:0] COUNT_RESET    = 32'h00000000;
  localparam logic [15:0] GUARD_UNLOCK   = 16'hce80;
  localparam int          BIT_WRAP_BUF_VALID = 0;
endpackage

// File: logic/timer_flag_regs.sv
// timer flag, enable, wrap limit, counter and guard register slice
// assumes counting engine and channels on the same clock drive the strobes
`timescale 1ns/10ps
`default_nettype none
module timer_flag_regs
  import timer_flag_pkg::*;
#(
  parameter int NCHAN = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire logic             read_clear_en,
  input  wire logic [NCHAN-1:0] chan_event,
  input  wire logic [NCHAN-1:0] capture_overrun,
  input  wire logic             overflow_event,
  input  wire logic             underflow_event,
  input  wire logic             direction_change,
  input  wire logic             quad_mode,
  input  wire logic             update_event,
  input  wire logic             hw_wrap_load,
  input  wire logic [31:0]      hw_wrap_value,
  input  wire logic             hw_count_load,
  input  wire logic [31:0]      hw_count_value,
  output logic      [31:0]      wrap_limit,
  output logic      [31:0]      count_value,
  output logic                  guard_locked,
  output logic                  irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enables;
    logic [31:0]       wrap;
    logic [31:0]       wrap_buf;
    logic              wrap_buf_valid;
    logic [31:0]       count;
    logic              locked;
    logic [31:0]       rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic   rst_core_n;
  logic   rst_meta_r;
  logic   rst_hold_r;

  // ----------------------------------------------------------------
  // reset release through two flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_hold_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_hold_r <= rst_meta_r;
    end
  end
  assign rst_core_n = rst_hold_r;

  // ----------------------------------------------------------------
  // access strobes
  // ----------------------------------------------------------------
  logic              wr_hit;
  logic              rd_hit;

  // a strobe only counts while the enable runs; a frozen block drops
  // the access whole instead of taking half of it
  assign wr_hit = reg_wr && clk_en;
  assign rd_hit = reg_rd && clk_en;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic              sel_flags;
  logic              sel_flag_set;
  logic              sel_flag_clear;
  logic              sel_flag_en;
  logic              sel_wrap;
  logic              sel_wrap_buf;
  logic              sel_count;
  logic              sel_status;
  logic              sel_guard;

  // full byte compare, so no register answers at an alias offset
  assign sel_flags      = (reg_addr == OFF_FLAGS);
  assign sel_flag_set   = (reg_addr == OFF_FLAG_SET);
  assign sel_flag_clear = (reg_addr == OFF_FLAG_CLEAR);
  assign sel_flag_en    = (reg_addr == OFF_FLAG_EN);
  assign sel_wrap       = (reg_addr == OFF_WRAP);
  assign sel_wrap_buf   = (reg_addr == OFF_WRAP_BUF);
  assign sel_count      = (reg_addr == OFF_COUNT);
  assign sel_status     = (reg_addr == OFF_STATUS);
  assign sel_guard      = (reg_addr == OFF_GUARD);

  // ----------------------------------------------------------------
  // qualified accesses
  // ----------------------------------------------------------------
  logic              wr_flag_set;
  logic              wr_flag_clear;
  logic              wr_flag_en;
  logic              wr_wrap;
  logic              wr_wrap_buf;
  logic              wr_count;
  logic              wr_guard;
  logic              rd_clear;

  // the lock gates protected writes here, once, not at every use;
  // flag and buffer registers stay writable while locked
  assign wr_flag_set   = wr_hit && sel_flag_set;
  assign wr_flag_clear = wr_hit && sel_flag_clear;
  assign wr_flag_en    = wr_hit && sel_flag_en;
  assign wr_wrap       = wr_hit && sel_wrap && !st_r.locked;
  assign wr_wrap_buf   = wr_hit && sel_wrap_buf;
  assign wr_count      = wr_hit && sel_count && !st_r.locked;
  assign wr_guard      = wr_hit && sel_guard;
  assign rd_clear      = rd_hit && sel_flag_clear && read_clear_en;

  // ----------------------------------------------------------------
  // guard key
  // ----------------------------------------------------------------
  logic [15:0]       guard_key;
  logic              key_unlocks;

  // only the low half carries the key; the upper half is reserved
  assign guard_key   = reg_wdata[15:0];
  assign key_unlocks = (guard_key == GUARD_UNLOCK);

  // ----------------------------------------------------------------
  // flag sources
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] hw_set;
  logic [FLAG_W-1:0] sw_set;
  logic [FLAG_W-1:0] sw_clr;
  logic [FLAG_W-1:0] flag_nxt;

  // hardware event strobes gathered into the flag layout
  always_comb begin
    hw_set = '0;
    hw_set[BIT_OVERFLOW]  = overflow_event;
    hw_set[BIT_UNDERFLOW] = underflow_event;
    hw_set[BIT_DIRCHANGE] = direction_change && quad_mode;
    hw_set[BIT_CHAN_LO +: NCHAN] = chan_event;
    hw_set[BIT_OVR_LO +: NCHAN]  = capture_overrun;
  end

  // software set and clear masks; a read-clear takes the live flags
  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    if (wr_flag_set) begin
      sw_set = reg_wdata[FLAG_W-1:0] & FLAG_VALID;
    end
    if (wr_flag_clear) begin
      sw_clr = reg_wdata[FLAG_W-1:0];
    end
    if (rd_clear) begin
      sw_clr = st_r.flags;
    end
  end

  // per-bit update: set beats clear, so an event in the clearing
  // cycle is never lost; reserved positions stay zero
  for (genvar gi = 0; gi < FLAG_W; gi++) begin : g_flag
    assign flag_nxt[gi] = FLAG_VALID[gi]
                        & (hw_set[gi] | sw_set[gi] | (st_r.flags[gi] & ~sw_clr[gi]));
  end

  // ----------------------------------------------------------------
  // read-back word
  // ----------------------------------------------------------------
  logic [31:0]       rd_word;

  // flag-clear reads zero unless the read-clear option is on, so a
  // plain poll of that offset never looks like pending events
  always_comb begin
    rd_word = 32'h00000000;
    if (sel_flags) begin
      rd_word = {20'h00000, st_r.flags};
    end
    if (sel_flag_clear) begin
      rd_word = read_clear_en ? {20'h00000, st_r.flags} : 32'h00000000;
    end
    if (sel_flag_en) begin
      rd_word = {20'h00000, st_r.enables};
    end
    if (sel_wrap) begin
      rd_word = st_r.wrap;
    end
    if (sel_wrap_buf) begin
      rd_word = st_r.wrap_buf;
    end
    if (sel_count) begin
      rd_word = st_r.count;
    end
    if (sel_status) begin
      rd_word[BIT_WRAP_BUF_VALID] = st_r.wrap_buf_valid;
    end
    if (sel_guard) begin
      rd_word = {31'h0, st_r.locked};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one place builds the next copy of all state
  always_comb begin
    st_nxt = st_r;
    st_nxt.flags = flag_nxt;

    if (wr_flag_en) begin
      st_nxt.enables = reg_wdata[FLAG_W-1:0] & FLAG_VALID;
    end

    // wrap limit, lowest priority first: hardware load, pending
    // transfer, software write; the later assignment wins
    if (hw_wrap_load) begin
      st_nxt.wrap = hw_wrap_value;
    end
    if (update_event && st_r.wrap_buf_valid) begin
      st_nxt.wrap           = st_r.wrap_buf;
      st_nxt.wrap_buf_valid = 1'b0;
    end
    if (wr_wrap) begin
      st_nxt.wrap           = reg_wdata;
      st_nxt.wrap_buf_valid = 1'b0;                                  // stale pending value dropped
    end
    // buffer is outside the protected set, so it takes writes locked
    if (wr_wrap_buf) begin
      st_nxt.wrap_buf       = reg_wdata;
      st_nxt.wrap_buf_valid = 1'b1;
    end

    // counter: a software write beats a hardware load in one cycle
    if (hw_count_load) begin
      st_nxt.count = hw_count_value;
    end
    if (wr_count) begin
      st_nxt.count = reg_wdata;
    end

    // any key but the unlock code locks
    if (wr_guard) begin
      st_nxt.locked = !key_unlocks;
    end

    // read data stand only in the cycle after the strobe
    st_nxt.rdata = rd_hit ? rd_word : 32'h00000000;

    // enable low: hold everything, read data return to zero
    if (!clk_en) begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_core_n) begin
    if (!rst_core_n) begin
      st_r.flags          <= '0;
      st_r.enables        <= '0;
      st_r.wrap           <= WRAP_RESET;
      st_r.wrap_buf       <= WRAP_BUF_RESET;
      st_r.wrap_buf_valid <= 1'b0;
      st_r.count          <= COUNT_RESET;
      st_r.locked         <= 1'b0;
      st_r.rdata          <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata    = st_r.rdata;
  assign wrap_limit   = st_r.wrap;
  assign count_value  = st_r.count;
  assign guard_locked = st_r.locked;
  assign irq          = |(st_r.flags & st_r.enables);
endmodule
`default_nettype wire

// File: dv/timer_flag_regs_asserts.sv
// checker: port-level properties of the timer flag and guard slice
// assumes clk_en high around guard, wrap and counter accesses
`timescale 1ns/10ps
`default_nettype none
module timer_flag_regs_asserts
  import timer_flag_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        update_event,
  input wire logic        hw_wrap_load,
  input wire logic [31:0] hw_wrap_value,
  input wire logic        hw_count_load,
  input wire logic [31:0] wrap_limit,
  input wire logic [31:0] count_value,
  input wire logic        guard_locked,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // guard key, protected writes, limit transfer
  // ----------------------------------------------------------------
  sequence s_buf_then_upd;
    reg_wr && reg_addr == OFF_WRAP_BUF ##2 update_event && !reg_wr;
  endsequence
  a_guard_lock_key: assert property (
    reg_wr && reg_addr == OFF_GUARD && reg_wdata[15:0] != GUARD_UNLOCK |=> guard_locked)
    else $error("guard did not lock");
  a_guard_unlock_key: assert property (
    reg_wr && reg_addr == OFF_GUARD && reg_wdata[15:0] == GUARD_UNLOCK |=> !guard_locked)
    else $error("guard did not unlock");
  a_guard_read_bit: assert property (
    reg_rd && reg_addr == OFF_GUARD |=> reg_rdata == {31'h0, $past(guard_locked)})
    else $error("guard read wrong");
  a_wrap_lock_hold: assert property (
    guard_locked && reg_wr && reg_addr == OFF_WRAP && !update_event && !hw_wrap_load
    |=> $stable(wrap_limit)) else $error("locked wrap limit changed");
  a_count_lock_hold: assert property (
    guard_locked && reg_wr && reg_addr == OFF_COUNT && !hw_count_load
    |=> $stable(count_value)) else $error("locked counter changed");
  a_wrap_sw_write: assert property (
    !guard_locked && reg_wr && reg_addr == OFF_WRAP |=> wrap_limit == $past(reg_wdata))
    else $error("wrap write lost");
  a_wrap_hw_load: assert property (
    hw_wrap_load && !update_event && !(reg_wr && reg_addr == OFF_WRAP)
    |=> wrap_limit == $past(hw_wrap_value)) else $error("hw wrap load lost");
  a_buf_transfer: assert property (
    s_buf_then_upd |=> wrap_limit == $past(reg_wdata, 3)) else $error("buffer not moved");
  a_irq_all_masked: assert property (
    reg_wr && reg_addr == OFF_FLAG_EN && reg_wdata == 32'h0 |=> !irq)
    else $error("irq with all enables off");
endmodule
bind timer_flag_regs timer_flag_regs_asserts i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .update_event(update_event), .hw_wrap_load(hw_wrap_load),
  .hw_wrap_value(hw_wrap_value), .hw_count_load(hw_count_load), .wrap_limit(wrap_limit),
  .count_value(count_value), .guard_locked(guard_locked), .irq(irq));
`default_nettype wire

// File: dv/timer_flag_regs_tb.sv
// bench: register, event, limit and guard tests of the timer flag slice
// assumes the design and its bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module timer_flag_regs_tb
  import timer_flag_pkg::*;
;
  logic        clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rce = 0, qm = 1, ce = 1;
  logic        upd = 0, hwl = 0, hcl = 0, irq, locked;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, rdata, wl, cv;
  logic [11:0] ev = 0;
  int          err_total = 0, checks_done = 0, cyc = 0;
  logic [7:0]  offs[7] = '{8'h0c, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c, 8'h40};
  logic [31:0] rstv[7] = '{0, 0, 32'h0000ffff, 0, 0, 0, 0};
  timer_flag_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .read_clear_en(rce), .chan_event(ev[7:4]), .capture_overrun(ev[11:8]),
    .overflow_event(ev[0]), .underflow_event(ev[1]), .direction_change(ev[2]),
    .quad_mode(qm), .update_event(upd), .hw_wrap_load(hwl), .hw_wrap_value(32'h00005555),
    .hw_count_load(hcl), .hw_count_value(32'h00007777), .wrap_limit(wl),
    .count_value(cv), .guard_locked(locked), .irq(irq));
  // ----------------------------------------------------------------
  // clock, hang guard, access tasks
  // ----------------------------------------------------------------
  initial forever #5 clk_sys = ~clk_sys;
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // one-cycle hardware strobes: events, update, wrap and count loads
  task automatic hw(input logic [11:0] v, input logic u, input logic w, input logic c);
    @(posedge clk_sys);
    {ev, upd, hwl, hcl} <= {v, u, w, c};
    @(posedge clk_sys);
    {ev, upd, hwl, hcl} <= '0;
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (offs[i]) rd(offs[i], rstv[i]);
    wr(OFF_FLAG_EN, 32'h00000ff7); rd(OFF_FLAG_EN, 32'h00000ff7);
    // each source alone, so a swapped bit shows up
    for (int b = 0; b < FLAG_W; b++) if (FLAG_VALID[b]) begin
      hw(12'h001 << b, 1'b0, 1'b0, 1'b0);
      chk(irq, 1);
      rd(OFF_FLAGS, 32'h1 << b);
      wr(OFF_FLAG_CLEAR, 32'h1 << b); rd(OFF_FLAGS, 0);
      chk(irq, 0);
    end
    @(posedge clk_sys) qm <= 1'b0;
    hw(12'h004, 1'b0, 1'b0, 1'b0); rd(OFF_FLAGS, 0);
    wr(OFF_FLAG_SET, 32'h00000ff7); rd(OFF_FLAGS, 32'hff7);
    wr(OFF_FLAG_CLEAR, 32'h0000000f); rd(OFF_FLAGS, 32'hff0);
    wr(OFF_FLAG_EN, 32'h0); rd(OFF_FLAG_CLEAR, 0);
    chk(irq, 0);
    @(posedge clk_sys) ce <= 1'b0; // enable low freezes every register but the read data, which return to zero
    wr(OFF_FLAG_EN, 32'h00000ff7); rd(OFF_FLAG_EN, 0);
    @(posedge clk_sys) ce <= 1'b1;
    rd(OFF_FLAG_EN, 0); chk(irq, 0);
    @(posedge clk_sys) rce <= 1'b1;
    rd(OFF_FLAG_CLEAR, 32'hff0); rd(OFF_FLAGS, 0);
    wr(OFF_WRAP, 32'h00001234); rd(OFF_WRAP, 32'h1234); chk(wl, 32'h1234);
    wr(OFF_WRAP_BUF, 32'h00000abc); hw(0, 1'b1, 1'b0, 1'b0);
    rd(OFF_WRAP, 32'habc); rd(OFF_STATUS, 0); rd(OFF_WRAP_BUF, 32'habc);
    hw(0, 1'b0, 1'b1, 1'b1); rd(OFF_WRAP, 32'h5555); rd(OFF_COUNT, 32'h7777);
    chk(wl, 32'h5555); chk(cv, 32'h7777);
    wr(OFF_GUARD, 32'h00001234); rd(OFF_GUARD, 1); chk(locked, 1);
    wr(OFF_WRAP, 32'h1); wr(OFF_COUNT, 32'h2);
    rd(OFF_WRAP, 32'h5555); rd(OFF_COUNT, 32'h7777);
    wr(OFF_GUARD, 32'h0000ce80); rd(OFF_GUARD, 0); chk(locked, 0);
    wr(OFF_COUNT, 32'h2); rd(OFF_COUNT, 32'h2); chk(cv, 32'h2);
    give_verdict;
  end
endmodule
`default_nettype wire
